// >>> mcuxs_core.sv
// Purpose: execution of table read, misc, skip, add and and instructions
// Assumes: software issues one instruction at a time over AXI4-Lite
// Notes: table word and skip condition arrive through registers
`include "mcuxs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mcuxs_core
    import mcuxs_pkg::*;
#(
    parameter int TBL_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mcuxs_state_type state_reg, state_next; // sequencer
    mcuxs_op_type op_reg, op_next; // instruction being run
    logic skip_reg, skip_next; // skip condition for skip ops
    logic [7:0] opnd_reg, opnd_next; // immediate operand for the immediate add
    logic [7:0] accumulator_reg, accumulator_next;
    logic [7:0] mem_reg, mem_next; // addressed data memory byte
    logic [TBL_W-1:0] tword_reg, tword_next; // table word presented
    logic [TBL_W-9:0] table_high_latch_reg, table_high_latch_next;
    mcuxs_flags_type flags_reg, flags_next;
    logic halt_reg, halt_next; // power-down state
    logic pre1_reg, pre1_next; // last op was first preclear
    logic [1:0] cyc_reg, cyc_next; // cycles used by last op
    logic aw_reg, aw_next; // write address held
    logic w_reg, w_next; // write data held
    logic [7:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next; // byte strobes taken with the data
    logic bv_reg, bv_next;
    logic [1:0] br_reg, br_next;
    logic rv_reg, rv_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0] rr_reg, rr_next;
    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    logic [7:0] add_b; // second addend
    logic cin; // carry in
    logic [4:0] lo_sum; // low nibble sum, bit4 is aux carry
    logic [8:0] sum; // full sum, bit8 is carry
    logic ovf; // signed overflow
    logic wr_go; // write both halves held, response free
    logic launch; // command register written while idle
    // adder shared by all five add forms
    always_comb begin
        add_b = (op_reg == MCUXS_OP_ADDI) ? opnd_reg : mem_reg;
        cin = (op_reg == MCUXS_OP_ADC || op_reg == MCUXS_OP_ADC_M) ?
            flags_reg.c : 1'b0;
        lo_sum = {1'b0, accumulator_reg[3:0]} + {1'b0, add_b[3:0]} +
            {4'h0, cin};
        sum = {1'b0, accumulator_reg} + {1'b0, add_b} + {8'h00, cin};
        // signs of operands agree but differ from the result
        ovf = (accumulator_reg[7] == add_b[7]) &&
            (sum[7] != accumulator_reg[7]);
    end
    // ------------------------------------------------------------
    // bus and execution next state
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_reg;
    assign s_axi_wready = !w_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rr_reg;
    assign wr_go = aw_reg && w_reg && !bv_reg;
    assign launch = wr_go && awa_reg == `MCUXS_OFF_CMD &&
        state_reg == MCUXS_ST_IDLE;
    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        rv_next = rv_reg;
        rd_next = rd_reg;
        rr_next = rr_reg;
        state_next = state_reg;
        op_next = op_reg;
        skip_next = skip_reg;
        opnd_next = opnd_reg;
        accumulator_next = accumulator_reg;
        mem_next = mem_reg;
        tword_next = tword_reg;
        table_high_latch_next = table_high_latch_reg;
        flags_next = flags_reg;
        halt_next = halt_reg;
        pre1_next = pre1_reg;
        cyc_next = cyc_reg;
        // take address and data in either order
        if (s_axi_awvalid && !aw_reg) begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_reg) begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        // perform a held write; strobe bit 0 gates the byte registers only, table and command writes ignore strobes
        if (wr_go) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = `MCUXS_RESP_OKAY;
            case (awa_reg)
                `MCUXS_OFF_CMD: begin
                    // a command while busy is refused with an error
                    if (launch) begin
                        op_next = mcuxs_op_type'(wd_reg[3:0]);
                        skip_next = wd_reg[8];
                        state_next = MCUXS_ST_EXEC;
                    end else begin
                        br_next = `MCUXS_RESP_SLVERR;
                    end
                end
                `MCUXS_OFF_OPND: begin
                    if (ws_reg[0]) opnd_next = wd_reg[7:0];
                end
                `MCUXS_OFF_ACCUM: begin
                    if (ws_reg[0]) accumulator_next = wd_reg[7:0];
                end
                `MCUXS_OFF_MEM: begin
                    if (ws_reg[0]) mem_next = wd_reg[7:0];
                end
                `MCUXS_OFF_TBL: begin
                    tword_next = wd_reg[TBL_W-1:0];
                end
                `MCUXS_OFF_STAT: begin
                    // software may preset the arithmetic flags
                    if (ws_reg[0]) begin
                        flags_next.c = wd_reg[`MCUXS_FLD_C];
                        flags_next.aux = wd_reg[`MCUXS_FLD_AUX];
                        flags_next.z = wd_reg[`MCUXS_FLD_Z];
                        flags_next.ovfl = wd_reg[`MCUXS_FLD_OVF];
                        halt_next = halt_reg & wd_reg[`MCUXS_FLD_HALT];
                    end
                end
                default: begin
                    br_next = `MCUXS_RESP_SLVERR;
                end
            endcase
        end
        // read channel, one cycle after arvalid
        if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
        if (s_axi_arvalid && !rv_reg) begin
            rv_next = 1'b1;
            rr_next = `MCUXS_RESP_OKAY;
            rd_next = 32'h0000_0000;
            case (s_axi_araddr)
                `MCUXS_OFF_CMD: rd_next[3:0] = op_reg;
                `MCUXS_OFF_OPND: rd_next[7:0] = opnd_reg;
                `MCUXS_OFF_ACCUM: rd_next[7:0] = accumulator_reg;
                `MCUXS_OFF_MEM: rd_next[7:0] = mem_reg;
                `MCUXS_OFF_TBL: rd_next[TBL_W-9:0] = table_high_latch_reg;
                `MCUXS_OFF_CYC: rd_next[1:0] = cyc_reg;
                `MCUXS_OFF_STAT: begin
                    rd_next[`MCUXS_FLD_C] = flags_reg.c;
                    rd_next[`MCUXS_FLD_AUX] = flags_reg.aux;
                    rd_next[`MCUXS_FLD_Z] = flags_reg.z;
                    rd_next[`MCUXS_FLD_OVF] = flags_reg.ovfl;
                    rd_next[`MCUXS_FLD_PWDN] = flags_reg.pwdn;
                    rd_next[`MCUXS_FLD_WDTO] = flags_reg.wdto;
                    rd_next[`MCUXS_FLD_HALT] = halt_reg;
                    rd_next[`MCUXS_FLD_BUSY] = state_reg != MCUXS_ST_IDLE;
                end
                default: rr_next = `MCUXS_RESP_SLVERR;
            endcase
        end
        // execute one instruction
        case (state_reg)
            MCUXS_ST_IDLE: begin
                state_next = state_next;
            end
            MCUXS_ST_EXEC: begin
                state_next = MCUXS_ST_IDLE;
                cyc_next = `MCUXS_ONE_CYC;
                pre1_next = 1'b0;
                case (op_reg)
                    MCUXS_OP_TBL_CUR, MCUXS_OP_TBL_LAST: begin
                        // same fetch path; table word supplied through the table register
                        table_high_latch_next = tword_reg[TBL_W-1:8];
                        mem_next = tword_reg[7:0];
                        cyc_next = `MCUXS_TWO_CYC;
                        state_next = MCUXS_ST_WAIT;
                    end
                    MCUXS_OP_SWAP: mem_next = {mem_reg[3:0], mem_reg[7:4]};
                    MCUXS_OP_SWAP_A: begin
                        accumulator_next = {mem_reg[3:0], mem_reg[7:4]};
                    end
                    MCUXS_OP_HALT: begin
                        halt_next = 1'b1;
                        flags_next.pwdn = 1'b1;
                        flags_next.wdto = 1'b0;
                    end
                    MCUXS_OP_PRE1: pre1_next = 1'b1;
                    MCUXS_OP_PRE2: begin
                        if (pre1_reg) begin
                            flags_next.wdto = 1'b0;
                            flags_next.pwdn = 1'b0;
                        end
                    end
                    MCUXS_OP_SKIP: begin
                        if (skip_reg) begin
                            cyc_next = `MCUXS_TWO_CYC;
                            state_next = MCUXS_ST_WAIT;
                        end
                    end
                    MCUXS_OP_PC_LO: begin
                        cyc_next = `MCUXS_TWO_CYC;
                        state_next = MCUXS_ST_WAIT;
                    end
                    MCUXS_OP_ADC, MCUXS_OP_ADD, MCUXS_OP_ADDI,
                    MCUXS_OP_ADC_M, MCUXS_OP_ADD_M: begin
                        if (op_reg == MCUXS_OP_ADC_M ||
                            op_reg == MCUXS_OP_ADD_M) begin
                            mem_next = sum[7:0];
                        end else begin
                            accumulator_next = sum[7:0];
                        end
                        flags_next.c = sum[8];
                        flags_next.aux = lo_sum[4];
                        flags_next.ovfl = ovf;
                        flags_next.z = sum[7:0] == 8'h00;
                    end
                    MCUXS_OP_AND: begin
                        accumulator_next = accumulator_reg & mem_reg;
                        flags_next.z = (accumulator_reg & mem_reg) == 8'h00;
                    end
                    default: begin
                        cyc_next = `MCUXS_ONE_CYC;
                    end
                endcase
            end
            MCUXS_ST_WAIT: state_next = MCUXS_ST_IDLE;
            default: state_next = MCUXS_ST_IDLE;
        endcase
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // synchronous reset to constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= MCUXS_ST_IDLE;
            op_reg <= MCUXS_OP_NOP;
            skip_reg <= 1'b0;
            opnd_reg <= 8'h00;
            accumulator_reg <= 8'h00;
            mem_reg <= 8'h00;
            tword_reg <= '0;
            table_high_latch_reg <= '0;
            flags_reg <= '0;
            halt_reg <= 1'b0;
            pre1_reg <= 1'b0;
            cyc_reg <= 2'h0;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awa_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            ws_reg <= 4'h0;
            bv_reg <= 1'b0;
            br_reg <= 2'h0;
            rv_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
            rr_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            skip_reg <= skip_next;
            opnd_reg <= opnd_next;
            accumulator_reg <= accumulator_next;
            mem_reg <= mem_next;
            tword_reg <= tword_next;
            table_high_latch_reg <= table_high_latch_next;
            flags_reg <= flags_next;
            halt_reg <= halt_next;
            pre1_reg <= pre1_next;
            cyc_reg <= cyc_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            rr_reg <= rr_next;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wire logic ex = state_reg == MCUXS_ST_EXEC;
    property p_tbl;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_TBL_CUR |=> mem_reg == $past(tword_reg[7:0])
            && state_reg == MCUXS_ST_WAIT ##1 state_reg == MCUXS_ST_IDLE;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table read wrong");
    property p_tbll;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_TBL_LAST |=> flags_reg == $past(flags_reg)
            && cyc_reg == 2'h2;
    endproperty
    a_tbll: assert property (p_tbll) else $error("last page bad");
    property p_swap_a;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_SWAP_A |=>
            accumulator_reg == {$past(mem_reg[3:0]), $past(mem_reg[7:4])};
    endproperty
    a_swap_a: assert property (p_swap_a) else $error("swap bad");
    property p_halt;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_HALT |=> halt_reg && flags_reg.pwdn;
    endproperty
    a_halt: assert property (p_halt) else $error("halt bad");
    property p_pre;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_PRE2 && !pre1_reg |=>
            flags_reg.wdto == $past(flags_reg.wdto) &&
            flags_reg.pwdn == $past(flags_reg.pwdn);
    endproperty
    a_pre: assert property (p_pre) else $error("preclear bad");
    property p_skip;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_SKIP |=> cyc_reg == ($past(skip_reg) ?
            2'h2 : 2'h1);
    endproperty
    a_skip: assert property (p_skip) else $error("skip cycles");
    property p_pc_lo;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_PC_LO |=> state_reg == MCUXS_ST_WAIT;
    endproperty
    a_pc_lo: assert property (p_pc_lo) else $error("pc cycles");
    property p_adc;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_ADC |=> accumulator_reg ==
            8'($past(accumulator_reg) + $past(mem_reg) + $past(flags_reg.c));
    endproperty
    a_adc: assert property (p_adc) else $error("adc bad");
    property p_and;
        @(posedge aclk) disable iff (!aresetn)
        ex && op_reg == MCUXS_OP_AND |=> flags_reg.c == $past(flags_reg.c)
            && flags_reg.z == (accumulator_reg == 8'h00);
    endproperty
    a_and: assert property (p_and) else $error("and bad");
    c_add: cover property (@(posedge aclk) ex && op_reg == MCUXS_OP_ADD_M);
    c_pre: cover property (@(posedge aclk)
        ex && op_reg == MCUXS_OP_PRE2 && pre1_reg);
    c_skip: cover property (@(posedge aclk)
        ex && op_reg == MCUXS_OP_SKIP && skip_reg);
endmodule
`default_nettype wire

// >>> mcuxs_cfg.svh
// Purpose: constants for the instruction execution subset block
// Assumes: aclk at 100 MHz, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
// Summary of operation
// - table read current page: latch high, byte to memory
// - last-page table read, two cycles, flags untouched
// - swap nibbles to memory or accumulator, no flags
// - power-down sets power-down flag, clears timeout flag
// - flags clear only after back-to-back preclears
// - skip takes two cycles, else one
// - program counter low writes take two cycles
// - add with carry into accumulator, four flags
// - add with carry into memory, four flags
// - add memory or immediate into accumulator
// - add accumulator into memory, four flags
// - and with memory into accumulator, zero only
`ifndef MCUXS_CFG_SVH
`define MCUXS_CFG_SVH
`define MCUXS_OFF_CMD 8'h00
`define MCUXS_OFF_OPND 8'h04
`define MCUXS_OFF_ACCUM 8'h08
`define MCUXS_OFF_STAT 8'h0c
`define MCUXS_OFF_MEM 8'h10
`define MCUXS_OFF_TBL 8'h14
`define MCUXS_OFF_CYC 8'h18
`define MCUXS_FLD_C 0
`define MCUXS_FLD_AUX 1
`define MCUXS_FLD_Z 2
`define MCUXS_FLD_OVF 3
`define MCUXS_FLD_PWDN 4
`define MCUXS_FLD_WDTO 5
`define MCUXS_FLD_HALT 6
`define MCUXS_FLD_BUSY 7
`define MCUXS_TWO_CYC 2'h2
`define MCUXS_ONE_CYC 2'h1
`define MCUXS_RESP_OKAY 2'h0
`define MCUXS_RESP_SLVERR 2'h2
`endif

// >>> mcuxs_pkg.sv
// Purpose: types for the instruction execution subset block
// Assumes: nothing beyond the constants header
// Notes: opcode codes follow declaration order from 0
package mcuxs_pkg;
    // operations this block executes
    typedef enum logic [3:0] {
        MCUXS_OP_NOP,
        MCUXS_OP_TBL_CUR,
        MCUXS_OP_TBL_LAST,
        MCUXS_OP_SWAP,
        MCUXS_OP_SWAP_A,
        MCUXS_OP_HALT,
        MCUXS_OP_PRE1,
        MCUXS_OP_PRE2,
        MCUXS_OP_SKIP,
        MCUXS_OP_PC_LO,
        MCUXS_OP_ADC,
        MCUXS_OP_ADC_M,
        MCUXS_OP_ADD,
        MCUXS_OP_ADDI,
        MCUXS_OP_ADD_M,
        MCUXS_OP_AND
    } mcuxs_op_type;
    // execution sequencer
    typedef enum logic [1:0] {
        MCUXS_ST_IDLE,
        MCUXS_ST_EXEC,
        MCUXS_ST_WAIT
    } mcuxs_state_type;
    // status flags
    typedef struct packed {
        logic wdto;
        logic pwdn;
        logic ovfl;
        logic z;
        logic aux;
        logic c;
    } mcuxs_flags_type;
endpackage

// >>> tb_top.sv
// Purpose: self-checking bench for the instruction execution subset
// Assumes: registers reached over AXI4-Lite, one command at a time
// Notes: expectations come from a small reference adder in this file
`include "mcuxs_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import mcuxs_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    int n_fail;
    int total_checks;
    mcuxs_op_type last_op; // previous command, for the preclear pair
    logic exp_pwdn; // tracked power-down flag
    logic exp_wdto; // tracked timeout flag
    logic [15:0] tword; // table word offered to the table reads
    logic [31:0] d0;
    logic [1:0] r0;

    mcuxs_core dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 100 MHz clock
    always #5 aclk = ~aclk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // reference add: {ovf, z, aux, c, sum}
    function automatic logic [11:0] add8(input logic [7:0] p, q,
                                         input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, p} + {1'b0, q} + {8'h0, ci};
        h = {1'b0, p[3:0]} + {1'b0, q[3:0]} + {4'h0, ci};
        add8 = {(p[7] == q[7]) && (s[7] != p[7]), s[7:0] == 8'h0, h[4],
                s[8], s[7:0]};
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ready is looked at mid-cycle, where it equals its value at the
    // next edge, so the release lands right after the taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
        int n;
        logic hs_aw, hs_w, hs_b;
        n = 0;
        hs_b = 1'b0;
        resp = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (hs_b !== 1'b1 && n < 50) begin
            @(negedge aclk);
            hs_aw = awvalid & awready;
            hs_w = wvalid & wready;
            hs_b = bvalid & bready;
            if (hs_b === 1'b1) resp = bresp;
            @(posedge aclk);
            if (hs_aw === 1'b1) awvalid <= 1'b0;
            if (hs_w === 1'b1) wvalid <= 1'b0;
            if (hs_b === 1'b1) bready <= 1'b0;
            n++;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        int n;
        logic hs_ar, hs_r;
        n = 0;
        hs_r = 1'b0;
        d = 32'h0;
        resp = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (hs_r !== 1'b1 && n < 50) begin
            @(negedge aclk);
            hs_ar = arvalid & arready;
            hs_r = rvalid & rready;
            if (hs_r === 1'b1) begin
                d = rdata;
                resp = rresp;
            end
            @(posedge aclk);
            if (hs_ar === 1'b1) arvalid <= 1'b0;
            if (hs_r === 1'b1) rready <= 1'b0;
            n++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk({30'h0, r}, {30'h0, `MCUXS_RESP_OKAY}, "write response");
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        axi_rd(a, d, r);
        chk({30'h0, r}, {30'h0, `MCUXS_RESP_OKAY}, "read response");
    endtask

    // ------------------------------------------------------------
    // one instruction: load operands, issue, wait, compare all
    // ------------------------------------------------------------
    task automatic run_op(input mcuxs_op_type op, input logic [7:0] a, m,
                          x, input logic [3:0] fl, input logic sk);
        logic [7:0] ea, em;
        logic [3:0] ef; // {ovf, z, aux, c}
        logic [1:0] ec;
        logic [11:0] r;
        logic [31:0] d;
        int n;
        ea = a;
        em = m;
        ef = fl;
        ec = `MCUXS_ONE_CYC;
        n = 0;
        r = add8(a, (op == MCUXS_OP_ADDI) ? x : m,
                 (op == MCUXS_OP_ADC || op == MCUXS_OP_ADC_M) ? fl[0] : 1'b0);
        case (op)
            MCUXS_OP_ADD, MCUXS_OP_ADC, MCUXS_OP_ADDI: begin
                ea = r[7:0];
                ef = r[11:8];
            end
            MCUXS_OP_ADD_M, MCUXS_OP_ADC_M: begin
                em = r[7:0];
                ef = r[11:8];
            end
            MCUXS_OP_AND: begin
                ea = a & m;
                ef[2] = (ea == 8'h0);
            end
            MCUXS_OP_SWAP: em = {m[3:0], m[7:4]};
            MCUXS_OP_SWAP_A: ea = {m[3:0], m[7:4]};
            MCUXS_OP_TBL_CUR, MCUXS_OP_TBL_LAST: begin
                em = tword[7:0];
                ec = `MCUXS_TWO_CYC;
            end
            MCUXS_OP_PC_LO: ec = `MCUXS_TWO_CYC;
            MCUXS_OP_SKIP: ec = sk ? `MCUXS_TWO_CYC : `MCUXS_ONE_CYC;
            MCUXS_OP_HALT: begin
                exp_pwdn = 1'b1;
                exp_wdto = 1'b0;
            end
            MCUXS_OP_PRE2: if (last_op == MCUXS_OP_PRE1) begin
                exp_pwdn = 1'b0;
                exp_wdto = 1'b0;
            end
            default: ;
        endcase
        last_op = op;
        // plain register writes are not commands, so a pair stays intact
        wr(`MCUXS_OFF_TBL, {16'h0, tword});
        wr(`MCUXS_OFF_ACCUM, {24'h0, a});
        wr(`MCUXS_OFF_MEM, {24'h0, m});
        wr(`MCUXS_OFF_OPND, {24'h0, x});
        wr(`MCUXS_OFF_STAT, {28'h0, fl});
        wr(`MCUXS_OFF_CMD, {23'h0, sk, 4'h0, op});
        d = 32'h80;
        while (d[`MCUXS_FLD_BUSY] !== 1'b0 && n < 20) begin
            rd(`MCUXS_OFF_STAT, d);
            n++;
        end
        chk({24'h0, d[7:0]}, {25'h0, op == MCUXS_OP_HALT, exp_wdto, exp_pwdn,
            ef}, "status");
        rd(`MCUXS_OFF_ACCUM, d);
        chk({24'h0, d[7:0]}, {24'h0, ea}, "accumulator");
        rd(`MCUXS_OFF_MEM, d);
        chk({24'h0, d[7:0]}, {24'h0, em}, "memory");
        rd(`MCUXS_OFF_CYC, d);
        chk({30'h0, d[1:0]}, {30'h0, ec}, "cycles");
        if (op == MCUXS_OP_TBL_CUR || op == MCUXS_OP_TBL_LAST) begin
            rd(`MCUXS_OFF_TBL, d);
            chk({24'h0, d[7:0]}, {24'h0, tword[15:8]}, "high latch");
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn <= 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
        awaddr <= 8'h0;
        araddr <= 8'h0;
        wdata <= 32'h0;
        wstrb <= 4'hf;
        last_op = MCUXS_OP_NOP;
        tword = 16'h5ac3;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // halt first so the tracked wake flags are known
        run_op(MCUXS_OP_HALT, 8'h11, 8'h22, 8'h33, 4'h6, 1'b0);
        run_op(MCUXS_OP_PRE1, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0);
        run_op(MCUXS_OP_NOP, 8'h01, 8'h02, 8'h03, 4'h9, 1'b0);
        run_op(MCUXS_OP_PRE2, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0);
        run_op(MCUXS_OP_PRE1, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0);
        run_op(MCUXS_OP_PRE2, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0);
        run_op(MCUXS_OP_TBL_CUR, 8'h44, 8'h55, 8'h0, 4'hf, 1'b0);
        tword = 16'ha53c;
        run_op(MCUXS_OP_TBL_LAST, 8'h66, 8'h77, 8'h0, 4'h5, 1'b0);
        run_op(MCUXS_OP_SWAP, 8'h12, 8'h3c, 8'h0, 4'ha, 1'b0);
        run_op(MCUXS_OP_SWAP_A, 8'h12, 8'hf1, 8'h0, 4'h5, 1'b0);
        run_op(MCUXS_OP_SKIP, 8'h0, 8'h0, 8'h0, 4'h0, 1'b1);
        run_op(MCUXS_OP_SKIP, 8'h0, 8'h0, 8'h0, 4'h0, 1'b0);
        run_op(MCUXS_OP_PC_LO, 8'h0, 8'h0, 8'h0, 4'h3, 1'b0);
        run_op(MCUXS_OP_ADC, 8'h7f, 8'h00, 8'h0, 4'h1, 1'b0);
        run_op(MCUXS_OP_ADC, 8'hff, 8'h00, 8'h0, 4'h1, 1'b0);
        run_op(MCUXS_OP_ADC_M, 8'h08, 8'h07, 8'h0, 4'h1, 1'b0);
        run_op(MCUXS_OP_ADD, 8'h80, 8'h80, 8'h0, 4'h0, 1'b0);
        run_op(MCUXS_OP_ADDI, 8'h0f, 8'h99, 8'h01, 4'h1, 1'b0);
        run_op(MCUXS_OP_ADD_M, 8'h50, 8'h50, 8'h0, 4'h0, 1'b0);
        run_op(MCUXS_OP_AND, 8'hf0, 8'h0f, 8'h0, 4'hb, 1'b0);
        run_op(MCUXS_OP_AND, 8'hf3, 8'h3f, 8'h0, 4'hf, 1'b0);
        // unmapped offset is refused on both channels
        axi_wr(8'h1c, 32'h1, r0);
        chk({30'h0, r0}, {30'h0, `MCUXS_RESP_SLVERR}, "unmapped write");
        axi_rd(8'h1c, d0, r0);
        chk({30'h0, r0}, {30'h0, `MCUXS_RESP_SLVERR}, "unmapped read");
        end_of_test();
    end

    // watchdog: the run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge aclk);
        $display("[ERR] %0t watchdog expired", $time);
        n_fail++;
        end_of_test();
    end
endmodule
`default_nettype wire
